/* verilog/rtcscp_pkg.sv */
package rtcscp_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SPIKE_NS = 100;
   localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] FILT_CNT = 4'(SPIKE_CYC + 1);
   // ==========================================================
   // addressing
   localparam logic [4:0] ADDR_FIXED_DEFAULT = 5'h14;
   localparam int BIT_RW = 0;
   localparam int BIT_CMD_HI = 7;
   localparam int BIT_BANK = 3;
   // ==========================================================
   // command field
   localparam logic [2:0] CMD_REG_ACCESS = 3'h0;
   localparam logic [2:0] CMD_READ_FLAGS = 3'h1;
   localparam logic [2:0] CMD_PRESC_CLEAR = 3'h2;
   localparam logic [2:0] CMD_TIME_ADJUST = 3'h3;
   localparam logic [2:0] CMD_CLR_NODATE = 3'h4;
   localparam logic [2:0] CMD_SET_NODATE = 3'h5;
   localparam logic [2:0] CMD_CLR_ALARM = 3'h6;
   // ==========================================================
   // target index and field masks
   localparam logic [1:0] IDX_HOURS = 2'h0;
   localparam logic [1:0] IDX_MINUTES = 2'h1;
   localparam logic [1:0] IDX_DAYS = 2'h2;
   localparam logic [1:0] IDX_MONTHS = 2'h3;
   localparam logic [7:0] MASK_HOURS = 8'h3F;
   localparam logic [7:0] MASK_MINUTES = 8'h7F;
   localparam logic [7:0] MASK_DAYS = 8'h3F;
   localparam logic [7:0] MASK_MONTHS = 8'h1F;
   localparam logic [6:0] SEC_ADJ_LIMIT = 7'h30;
   // ==========================================================
   // flag byte layout and reset values
   localparam int FLAG_MIN = 4;
   localparam int FLAG_SEC = 3;
   localparam int FLAG_NODATE = 2;
   localparam int FLAG_ALARM = 1;
   localparam int FLAG_SUPPLY = 0;
   localparam logic [7:0] ALARM_RESET = 8'h00;
   localparam logic [2:0] TARGET_RESET = 3'h0;
   // ==========================================================
   // types
   typedef struct packed {
      logic [7:0] months;
      logic [7:0] days;
      logic [7:0] hours;
      logic [7:0] minutes;
   } rtcscp_time_t;
   typedef struct packed {
      logic [1:0] index;
      logic [7:0] data;
   } rtcscp_twr_t;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} rtcscp_state_t;
endpackage

/* verilog/rtcscp_port.sv */
`timescale 1ns/1ps
module rtcscp_port
#(
   parameter logic [4:0] ADDR_FIXED = rtcscp_pkg::ADDR_FIXED_DEFAULT
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_select_hi,
   input wire logic addr_select_lo,
   input wire logic [6:0] seconds_count,
   input wire logic minute_pulse_level,
   input wire logic seconds_pulse,
   input wire logic power_fail_event,
   input wire logic compare_strobe,
   input wire rtcscp_pkg::rtcscp_time_t time_in,
   output rtcscp_pkg::rtcscp_twr_t time_wr,
   output logic time_wr_strobe,
   output logic prescaler_clear,
   output logic minute_advance,
   output logic alarm_match,
   output logic ignore_date_flag,
   output logic supply_fail_flag
);
   // ==========================================================
   // pin synchroniser and spike filter
   logic [3:0] pin_raw;
   logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
   logic [3:0][3:0] cnt_reg, cnt_next;

   assign pin_raw = {addr_select_hi, addr_select_lo, sda_in, scl_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_pin
         always_comb
         begin
            filt_next[gi] = filt_reg[gi];
            cnt_next[gi] = 4'h0;
            if (s2_reg[gi] == s3_reg[gi] && s3_reg[gi] != filt_reg[gi])
            begin
               cnt_next[gi] = cnt_reg[gi] + 4'h1;
               if (cnt_next[gi] == rtcscp_pkg::FILT_CNT)
               begin
                  filt_next[gi] = s3_reg[gi];
                  cnt_next[gi] = 4'h0;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         s1_reg <= 4'hF;
         s2_reg <= 4'hF;
         s3_reg <= 4'hF;
         filt_reg <= 4'hF;
         cnt_reg <= '0;
      end
      else if (ce)
      begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
         cnt_reg <= cnt_next;
      end
   end

   // ==========================================================
   // bus events
   logic scl_f, sda_f, scl_old_reg, sda_old_reg;
   logic scl_rise, scl_fall, bus_start, bus_stop;

   assign scl_f = filt_reg[0];
   assign sda_f = filt_reg[1];
   logic addr_select_hi_f, addr_select_lo_f;
   assign addr_select_hi_f = filt_reg[3];
   assign addr_select_lo_f = filt_reg[2];
   assign scl_rise = scl_f && !scl_old_reg;
   assign scl_fall = !scl_f && scl_old_reg;
   assign bus_start = scl_f && scl_old_reg && !sda_f && sda_old_reg;
   assign bus_stop = scl_f && scl_old_reg && sda_f && !sda_old_reg;

   // ==========================================================
   // protocol engine and registers
   rtcscp_pkg::rtcscp_state_t state_reg, state_next;
   logic [7:0] shift_reg, shift_next;
   logic [3:0] bits_reg, bits_next;
   logic first_reg, first_next;
   logic is_cmd_reg, is_cmd_next;
   logic read_reg, read_next;
   logic reg_mode_reg, reg_mode_next;
   logic flag_mode_reg, flag_mode_next;
   logic [2:0] target_reg, target_next;
   logic [3:0][7:0] alarm_reg, alarm_next;
   logic oe_reg, oe_next;
   logic nodate_reg, nodate_next, amatch_reg, amatch_next, sfail_reg, sfail_next;
   rtcscp_pkg::rtcscp_twr_t twr_reg, twr_next;
   logic twr_stb_reg, twr_stb_next, pclr_reg, pclr_next, madv_reg, madv_next;
   logic [3:0][7:0] masks;
   logic [7:0] tx_byte;
   logic [3:0][7:0] time_vec;
   logic cmd_ok, access_ok, amatch_set, alarm_clr_cmd;

   assign masks = {rtcscp_pkg::MASK_MONTHS, rtcscp_pkg::MASK_DAYS,
                   rtcscp_pkg::MASK_MINUTES, rtcscp_pkg::MASK_HOURS};
   assign time_vec = {time_in.months, time_in.days, time_in.minutes, time_in.hours};

   // alarm compare on the calendar's strobe
   assign amatch_set = compare_strobe
      && alarm_reg[rtcscp_pkg::IDX_HOURS] == time_in.hours
      && alarm_reg[rtcscp_pkg::IDX_MINUTES] == time_in.minutes
      && (nodate_reg
          || (alarm_reg[rtcscp_pkg::IDX_DAYS] == time_in.days
              && alarm_reg[rtcscp_pkg::IDX_MONTHS] == time_in.months));

   // read byte selection
   always_comb
   begin
      tx_byte = 8'h00;
      if (flag_mode_reg)
      begin
         tx_byte[rtcscp_pkg::FLAG_MIN] = minute_pulse_level;
         tx_byte[rtcscp_pkg::FLAG_SEC] = seconds_pulse;
         tx_byte[rtcscp_pkg::FLAG_NODATE] = nodate_reg;
         tx_byte[rtcscp_pkg::FLAG_ALARM] = amatch_reg;
         tx_byte[rtcscp_pkg::FLAG_SUPPLY] = sfail_reg;
      end
      else if (target_reg[2])
         tx_byte = alarm_reg[target_reg[1:0]] & masks[target_reg[1:0]];
      else
         tx_byte = time_vec[target_reg[1:0]] & masks[target_reg[1:0]];
   end

   assign cmd_ok = !shift_reg[rtcscp_pkg::BIT_CMD_HI]
      && ((shift_reg[6:4] == rtcscp_pkg::CMD_REG_ACCESS && !shift_reg[rtcscp_pkg::BIT_BANK])
          || (shift_reg[6:4] != rtcscp_pkg::CMD_REG_ACCESS && shift_reg[6:4] != 3'h7));
   assign access_ok = cmd_ok && shift_reg[6:4] == rtcscp_pkg::CMD_REG_ACCESS;
   assign alarm_clr_cmd = state_reg == rtcscp_pkg::ST_RX && scl_fall && bits_reg == 4'h8
      && !first_reg && is_cmd_reg && cmd_ok && shift_reg[6:4] == rtcscp_pkg::CMD_CLR_ALARM;

   always_comb
   begin
      state_next = state_reg;
      shift_next = shift_reg;
      bits_next = bits_reg;
      first_next = first_reg;
      is_cmd_next = is_cmd_reg;
      read_next = read_reg;
      reg_mode_next = reg_mode_reg;
      flag_mode_next = flag_mode_reg;
      target_next = target_reg;
      alarm_next = alarm_reg;
      oe_next = oe_reg;
      nodate_next = nodate_reg;
      sfail_next = sfail_reg;
      twr_next = twr_reg;
      twr_stb_next = 1'b0;
      pclr_next = 1'b0;
      madv_next = 1'b0;
      amatch_next = amatch_reg;
      if (alarm_clr_cmd)
         amatch_next = 1'b0;
      if (amatch_set)
         amatch_next = 1'b1;
      unique case (state_reg)
         rtcscp_pkg::ST_IDLE:
         begin
         end
         rtcscp_pkg::ST_RX:
         begin
            if (scl_rise && bits_reg != 4'h8)
            begin
               shift_next = {shift_reg[6:0], sda_f};
               bits_next = bits_reg + 4'h1;
            end
            else if (scl_fall && bits_reg == 4'h8)
            begin
               state_next = rtcscp_pkg::ST_ACK;
               oe_next = 1'b1;
               if (first_reg)
               begin
                  first_next = 1'b0;
                  is_cmd_next = 1'b1;
                  read_next = shift_reg[rtcscp_pkg::BIT_RW];
                  if (shift_reg[7:1] != {ADDR_FIXED, addr_select_hi_f, addr_select_lo_f})
                  begin
                     state_next = rtcscp_pkg::ST_IDLE;
                     oe_next = 1'b0;
                  end
               end
               else if (is_cmd_reg)
               begin
                  is_cmd_next = 1'b0;
                  if (!cmd_ok)
                  begin
                     state_next = rtcscp_pkg::ST_IDLE;
                     oe_next = 1'b0;
                  end
                  else
                  begin
                     reg_mode_next = access_ok;
                     flag_mode_next = shift_reg[6:4] == rtcscp_pkg::CMD_READ_FLAGS;
                     unique case (shift_reg[6:4])
                        rtcscp_pkg::CMD_REG_ACCESS:
                        begin
                           target_next = shift_reg[2:0];
                           sfail_next = 1'b0;
                        end
                        rtcscp_pkg::CMD_PRESC_CLEAR:
                           pclr_next = 1'b1;
                        rtcscp_pkg::CMD_TIME_ADJUST:
                        begin
                           pclr_next = 1'b1;
                           madv_next = seconds_count >= rtcscp_pkg::SEC_ADJ_LIMIT;
                        end
                        rtcscp_pkg::CMD_CLR_NODATE:
                           nodate_next = 1'b0;
                        rtcscp_pkg::CMD_SET_NODATE:
                           nodate_next = 1'b1;
                        default:
                        begin
                        end
                     endcase
                  end
               end
               else if (reg_mode_reg)
               begin
                  if (target_reg[2])
                     alarm_next[target_reg[1:0]] = shift_reg & masks[target_reg[1:0]];
                  else
                  begin
                     twr_next.index = target_reg[1:0];
                     twr_next.data = shift_reg & masks[target_reg[1:0]];
                     twr_stb_next = 1'b1;
                  end
                  target_next = {target_reg[2], target_reg[1:0] + 2'h1};
               end
               else
               begin
                  state_next = rtcscp_pkg::ST_IDLE;
                  oe_next = 1'b0;
               end
            end
         end
         rtcscp_pkg::ST_ACK:
         begin
            if (scl_fall)
            begin
               bits_next = 4'h0;
               if (read_reg && !first_reg)
               begin
                  state_next = rtcscp_pkg::ST_TX;
                  shift_next = tx_byte;
                  oe_next = !tx_byte[7];
               end
               else
               begin
                  state_next = rtcscp_pkg::ST_RX;
                  oe_next = 1'b0;
               end
            end
         end
         rtcscp_pkg::ST_TX:
         begin
            if (scl_fall)
            begin
               bits_next = bits_reg + 4'h1;
               shift_next = {shift_reg[6:0], 1'b0};
               if (bits_reg == 4'h7)
               begin
                  state_next = rtcscp_pkg::ST_TXACK;
                  oe_next = 1'b0;
               end
               else
                  oe_next = !shift_reg[6];
            end
         end
         rtcscp_pkg::ST_TXACK:
         begin
            if (scl_rise)
            begin
               if (sda_f)
                  state_next = rtcscp_pkg::ST_IDLE;
               else if (!flag_mode_reg)
                  target_next = {target_reg[2], target_reg[1:0] + 2'h1};
            end
            else if (scl_fall)
            begin
               state_next = rtcscp_pkg::ST_TX;
               bits_next = 4'h0;
               shift_next = tx_byte;
               oe_next = !tx_byte[7];
            end
         end
      endcase
      if (bus_stop)
      begin
         state_next = rtcscp_pkg::ST_IDLE;
         oe_next = 1'b0;
      end
      if (bus_start)
      begin
         state_next = rtcscp_pkg::ST_RX;
         bits_next = 4'h0;
         first_next = 1'b1;
         is_cmd_next = 1'b0;
         oe_next = 1'b0;
      end
      if (power_fail_event)
         sfail_next = 1'b1;
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         scl_old_reg <= 1'b1;
         sda_old_reg <= 1'b1;
         state_reg <= rtcscp_pkg::ST_IDLE;
         shift_reg <= 8'h00;
         bits_reg <= 4'h0;
         first_reg <= 1'b0;
         is_cmd_reg <= 1'b0;
         read_reg <= 1'b0;
         reg_mode_reg <= 1'b0;
         flag_mode_reg <= 1'b0;
         target_reg <= rtcscp_pkg::TARGET_RESET;
         alarm_reg <= {4{rtcscp_pkg::ALARM_RESET}};
         oe_reg <= 1'b0;
         nodate_reg <= 1'b0;
         amatch_reg <= 1'b0;
         sfail_reg <= 1'b0;
         twr_reg <= '0;
         twr_stb_reg <= 1'b0;
         pclr_reg <= 1'b0;
         madv_reg <= 1'b0;
      end
      else if (ce)
      begin
         scl_old_reg <= scl_f;
         sda_old_reg <= sda_f;
         state_reg <= state_next;
         shift_reg <= shift_next;
         bits_reg <= bits_next;
         first_reg <= first_next;
         is_cmd_reg <= is_cmd_next;
         read_reg <= read_next;
         reg_mode_reg <= reg_mode_next;
         flag_mode_reg <= flag_mode_next;
         target_reg <= target_next;
         alarm_reg <= alarm_next;
         oe_reg <= oe_next;
         nodate_reg <= nodate_next;
         amatch_reg <= amatch_next;
         sfail_reg <= sfail_next;
         twr_reg <= twr_next;
         twr_stb_reg <= twr_stb_next;
         pclr_reg <= pclr_next;
         madv_reg <= madv_next;
      end
   end

   // ==========================================================
   // outputs
   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;
   assign time_wr = twr_reg;
   assign time_wr_strobe = twr_stb_reg;
   assign prescaler_clear = pclr_reg;
   assign minute_advance = madv_reg;
   assign alarm_match = amatch_reg;
   assign ignore_date_flag = nodate_reg;
   assign supply_fail_flag = sfail_reg;
endmodule

/* tb/rtcscp_port_chk.sv */
`timescale 1ns/1ps
// ====
// port checker
module rtcscp_port_chk
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic power_fail_event,
   input wire logic compare_strobe,
   input wire rtcscp_pkg::rtcscp_twr_t time_wr,
   input wire logic time_wr_strobe,
   input wire logic prescaler_clear,
   input wire logic minute_advance,
   input wire logic alarm_match,
   input wire logic ignore_date_flag,
   input wire logic supply_fail_flag
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // acknowledge slot close by
   sequence s_ack_soon;
      ##[0:4] sda_oe;
   endsequence
   a_sda_low_only: assert property (sda_out == 1'h0)
      else $error("data line driven high");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data enable changed while clock high");
   a_presc_pulse: assert property (prescaler_clear |=> !prescaler_clear)
      else $error("prescaler clear longer than one cycle");
   a_adv_with_clr: assert property (minute_advance |-> prescaler_clear)
      else $error("minute advance without prescaler clear");
   a_wr_masked: assert property (time_wr_strobe |-> (time_wr.data & ~(
      (time_wr.index == rtcscp_pkg::IDX_MINUTES) ? 8'h7F :
      (time_wr.index == rtcscp_pkg::IDX_MONTHS) ? 8'h1F : 8'h3F)) == 8'h00)
      else $error("unused written bits not cleared");
   a_pf_sets: assert property (power_fail_event |=> supply_fail_flag)
      else $error("supply fail not latched");
   a_pf_clear: assert property ($fell(supply_fail_flag) |-> s_ack_soon)
      else $error("supply fail cleared outside a command");
   a_am_cause: assert property ($rose(alarm_match) |-> $past(compare_strobe))
      else $error("alarm set without compare");
   a_am_clear: assert property ($fell(alarm_match) |-> s_ack_soon)
      else $error("alarm cleared outside a command");
   a_nd_change: assert property ($changed(ignore_date_flag) |-> s_ack_soon)
      else $error("no-date flag changed outside a command");
endmodule

/* tb/rtcscp_master.sv */
`timescale 1ns/1ps
// ====
// bus master model, clock idles high
module rtcscp_master
(
   output logic scl,
   output logic sda_m,
   input wire logic sda
);
   localparam time Q = 240;
   initial
   begin
      scl = 1'h1;
      sda_m = 1'h1;
   end
   // start or repeated start, leaves clock low
   task automatic start();
      #Q sda_m = 1'h1;
      #Q scl = 1'h1;
      #(2*Q) sda_m = 1'h0;
      #(2*Q) scl = 1'h0;
   endtask
   task automatic bit_x(input logic b, output logic r);
      #Q sda_m = b;
      #Q scl = 1'h1;
      #Q r = sda;
      #Q scl = 1'h0;
   endtask
   // one byte plus acknowledge bit; mack high releases the line
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(tx[i], r);
         rx[i] = r;
      end
      bit_x(mack, r);
      ack = ~r;
   endtask
   task automatic stop();
      #Q sda_m = 1'h0;
      #Q scl = 1'h1;
      #(2*Q) sda_m = 1'h1;
      #(2*Q);
   endtask
   // short clock spike while low
   task automatic spike();
      #100 scl = 1'h1;
      #80 scl = 1'h0;
   endtask
endmodule

/* tb/tb_rtc_serial_command_port.sv */
`timescale 1ns/1ps
// ====
// bench top
module tb_rtc_serial_command_port;
   typedef struct packed {logic [7:0] cmd; logic [3:0] exp;} rtcscp_row_t;
   logic clk_sys, reset, scl, sda_m, sda, sda_out, sda_oe, a;
   logic [6:0] seconds_count;
   logic minute_pulse_level, seconds_pulse, power_fail_event, compare_strobe;
   rtcscp_pkg::rtcscp_time_t time_in;
   rtcscp_pkg::rtcscp_twr_t time_wr;
   logic time_wr_strobe, prescaler_clear, minute_advance;
   logic alarm_match, ignore_date_flag, supply_fail_flag;
   logic [7:0] v;
   logic [9:0] wq[$];
   int pc_cnt = 0, ma_cnt = 0, bad_count = 0, comparisons = 0, p0;
   // command, then {cmd ack, data ack, no-date, prescaler pulses}
   rtcscp_row_t rows [10] = '{'{8'h00, 4'hC}, '{8'h08, 4'h0}, '{8'h10, 4'h8},
      '{8'h20, 4'h9}, '{8'h30, 4'h9}, '{8'h40, 4'h8}, '{8'h50, 4'hA},
      '{8'h60, 4'hA}, '{8'h70, 4'h2}, '{8'h80, 4'h2}};
   logic [7:0] exp_r [4] = '{8'h1F, 8'h3F, 8'h7F, 8'h3F};
   logic [9:0] exp_w [3] = '{10'h31F, 10'h03F, 10'h17F};
   assign sda = sda_m & ~(sda_oe & ~sda_out);
   rtcscp_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
   rtcscp_port uut (.clk_sys(clk_sys), .reset(reset), .ce(1'h1), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_hi(1'h1),
      .addr_select_lo(1'h0), .seconds_count(seconds_count),
      .minute_pulse_level(minute_pulse_level), .seconds_pulse(seconds_pulse),
      .power_fail_event(power_fail_event), .compare_strobe(compare_strobe),
      .time_in(time_in), .time_wr(time_wr), .time_wr_strobe(time_wr_strobe),
      .prescaler_clear(prescaler_clear), .minute_advance(minute_advance),
      .alarm_match(alarm_match), .ignore_date_flag(ignore_date_flag),
      .supply_fail_flag(supply_fail_flag));
   initial
   begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      pc_cnt += (prescaler_clear === 1'h1);
      ma_cnt += (minute_advance === 1'h1);
      if (time_wr_strobe === 1'h1)
         wq.push_back(time_wr);
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [7:0] b);
      m.xfer(b, 1'h1, v, a);
   endtask
   task automatic start_addr(input logic rw);
      m.start();
      send({rtcscp_pkg::ADDR_FIXED_DEFAULT, 2'h2, rw});
      chk(a, 1'h1);
   endtask
   task automatic cmd(input logic [7:0] c);
      start_addr(1'h0);
      send(c);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic strobe();
      cyc(1);
      compare_strobe = 1'h1;
      cyc(1);
      compare_strobe = 1'h0;
      cyc(2);
   endtask
   task automatic summarize();
      $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ====
   // main sequence
   initial
   begin
      reset = 1'h1;
      {seconds_count, minute_pulse_level, seconds_pulse} = '0;
      {power_fail_event, compare_strobe} = '0;
      time_in = '0;
      cyc(6);
      reset = 1'h0;
      cyc(2);
      chk({sda_oe, alarm_match, ignore_date_flag, supply_fail_flag}, 16'h0);
      foreach (rows[i])
      begin
         p0 = pc_cnt;
         cmd(rows[i].cmd);
         chk(a, rows[i].exp[3]);
         send(8'hC5);
         chk(a, rows[i].exp[2]);
         m.stop();
         chk(ignore_date_flag, rows[i].exp[1]);
         chk(16'(pc_cnt - p0), rows[i].exp[0]);
      end
      chk(16'(wq.size()), 16'h1);
      chk(wq.pop_front(), 16'h005);
      cmd(8'h03);
      repeat (3) send(8'hFF);
      m.stop();
      foreach (exp_w[k]) chk(wq.pop_front(), exp_w[k]);
      cmd(8'h07);
      repeat (4) send(8'hFF);
      start_addr(1'h1);
      foreach (exp_r[k])
      begin
         m.xfer(8'hFF, k == 3, v, a);
         chk(v, exp_r[k]);
      end
      m.stop();
      chk(16'(wq.size()), 16'h0);
      time_in = 32'h00003F7F;
      strobe();
      chk(alarm_match, 1'h1);
      cmd(8'h60);
      m.stop();
      chk(alarm_match, 1'h0);
      cmd(8'h40);
      m.stop();
      strobe();
      chk(alarm_match, 1'h0);
      time_in = 32'h1F3F3F7F;
      strobe();
      chk(alarm_match, 1'h1);
      cyc(1);
      power_fail_event = 1'h1;
      minute_pulse_level = 1'h1;
      cyc(1);
      power_fail_event = 1'h0;
      cmd(8'h10);
      start_addr(1'h1);
      for (int k = 0; k < 2; k++)
      begin
         m.xfer(8'hFF, k == 1, v, a);
         chk(v, 8'h13);
      end
      m.stop();
      chk(supply_fail_flag, 1'h1);
      cmd(8'h00);
      m.stop();
      chk(supply_fail_flag, 1'h0);
      for (int k = 0; k < 2; k++)
      begin
         cyc(1);
         seconds_count = k ? 7'h30 : 7'h29;
         p0 = ma_cnt;
         cmd(8'h30);
         m.stop();
         chk(16'(ma_cnt - p0), 16'(k));
      end
      cyc(1);
      time_in = 32'hFFFFFFFF;
      cmd(8'h01);
      m.stop();
      start_addr(1'h1);
      m.xfer(8'hFF, 1'h0, v, a);
      chk(v, 8'h7F);
      m.xfer(8'hFF, 1'h1, v, a);
      chk(v, 8'h3F);
      m.stop();
      m.start();
      send({rtcscp_pkg::ADDR_FIXED_DEFAULT, 2'h1, 1'h0});
      chk(a, 1'h0);
      m.stop();
      m.start();
      m.spike();
      send({rtcscp_pkg::ADDR_FIXED_DEFAULT, 2'h2, 1'h0});
      chk(a, 1'h1);
      m.stop();
      summarize();
   end
endmodule
bind rtcscp_port rtcscp_port_chk chk (.clk_sys(clk_sys), .reset(reset), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .power_fail_event(power_fail_event),
   .compare_strobe(compare_strobe), .time_wr(time_wr), .time_wr_strobe(time_wr_strobe),
   .prescaler_clear(prescaler_clear), .minute_advance(minute_advance),
   .alarm_match(alarm_match), .ignore_date_flag(ignore_date_flag),
   .supply_fail_flag(supply_fail_flag));
